// File: tb/spv_programmer.sv
`timescale 1ns/100ps

module spv_programmer (
   // Link clock and data toward the device
   output logic serialProgClockPin,
   output logic pgmData,
   // Resolved data line
   input wire logic dataWire
);
   initial begin
      serialProgClockPin = 1'b0;
      pgmData = 1'b0;
   end

   task automatic clockBit(input logic b);
      pgmData = b;
      #15 serialProgClockPin = 1'b1;
      #15 serialProgClockPin = 1'b0;
   endtask

   task automatic idle(input int n);
      for (int i = 0; i < n; i++) clockBit(1'b0);
   endtask

   task automatic sendCmd(input logic [5:0] c);
      for (int i = 0; i < 6; i++) clockBit(c[i]);
      pgmData = 1'b0;
      #300;
   endtask

   task automatic sendWord(input logic [13:0] w);
      for (int i = 0; i < 14; i++) clockBit(w[i]);
      pgmData = 1'b0;
      #300;
   endtask

   // read phase; released line shows inverse of last level
   task automatic readWord(output logic [13:0] w);
      for (int i = 0; i < 15; i++) begin
         clockBit(~dataWire);
         if (i < 14) w[i] = dataWire;
      end
      pgmData = 1'b0;
      #300;
   endtask
endmodule // spv_programmer

// File: tb/tb_serial_program_verify_port.sv
`timescale 1ns/100ps

module tb_serial_program_verify_port;
   logic clk_sys, rst_n, clkEn, serialProgClockPin, pgmData, dataWire;
   logic serialProgDataPinOut, serialProgDataPinOe, highVoltageEntryLevel, lowVoltageEntryPin;
   logic lowVoltageProgEnable, codeProtectBit, dataProtectBit, progMode, deviceResetReq;
   logic entryPinIsGpio, userIdAccess, memValid, memReady, rdValid;
   logic [1:0] memOp;
   logic [13:0] readChecksum, memAddr, memWdata, rdData;
   logic [31:0] seed = 32'h951a;
   logic [31:0] r, rMem;
   logic [13:0] mem [logic [13:0]];
   logic [29:0] reqQ [$];
   logic [13:0] rdQ [$];
   int fails = 0;
   int checked = 0;

   assign dataWire = serialProgDataPinOe ? serialProgDataPinOut : pgmData;

   spv_programmer u_prog (.serialProgClockPin(serialProgClockPin), .pgmData(pgmData),
      .dataWire(dataWire));

   spv_prog_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
      .serialProgClockPin(serialProgClockPin), .serialProgDataPinIn(dataWire),
      .serialProgDataPinOut(serialProgDataPinOut), .serialProgDataPinOe(serialProgDataPinOe),
      .highVoltageEntryLevel(highVoltageEntryLevel), .lowVoltageEntryPin(lowVoltageEntryPin),
      .lowVoltageProgEnable(lowVoltageProgEnable), .codeProtectBit(codeProtectBit),
      .dataProtectBit(dataProtectBit), .progMode(progMode), .deviceResetReq(deviceResetReq),
      .entryPinIsGpio(entryPinIsGpio), .userIdAccess(userIdAccess),
      .readChecksum(readChecksum), .memValid(memValid), .memReady(memReady), .memOp(memOp),
      .memAddr(memAddr), .memWdata(memWdata), .rdValid(rdValid), .rdData(rdData));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [13:0] memRead(input logic [13:0] a);
      return mem.exists(a) ? mem[a] : 14'h3fff;
   endfunction

   function automatic logic [13:0] cfgExp(input logic [13:0] d, input logic lv);
      cfgExp = d;
      cfgExp[spv_pkg::CFG_CP_BIT] = d[spv_pkg::CFG_CP_BIT] & codeProtectBit;
      cfgExp[spv_pkg::CFG_CPD_BIT] = d[spv_pkg::CFG_CPD_BIT] & dataProtectBit;
      if (lv) cfgExp[spv_pkg::CFG_LVP_BIT] = lowVoltageProgEnable;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Memory model: random ready, reads answered with random latency
   always @(posedge clk_sys) begin
      if (rst_n && memValid === 1'b1 && memReady) begin
         reqQ.push_back({memOp, memAddr, memWdata});
         if (memOp === spv_pkg::MOP_READ) rdQ.push_back(memAddr);
         if (memOp === spv_pkg::MOP_WRITE) mem[memAddr] = memWdata;
         if (memOp === spv_pkg::MOP_ERASE) mem.delete();
      end
   end

   always @(negedge clk_sys) begin
      rMem = rnd();
      memReady <= rMem[1:0] != 2'h0;
      rdValid <= 1'b0;
      if (rdQ.size() > 0 && rMem[4]) begin
         rdValid <= 1'b1;
         rdData <= memRead(rdQ.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic takeReq(output logic [29:0] q);
      for (int n = 0; n < 300 && reqQ.size() == 0; n++) @(negedge clk_sys);
      q = (reqQ.size() > 0) ? reqQ.pop_front() : 'x;
   endtask

   task automatic readAt(input logic [13:0] a, output logic [13:0] w);
      logic [29:0] q;
      u_prog.sendCmd(spv_pkg::CMD_READ_PROG);
      takeReq(q);
      check(q[29:14], {spv_pkg::MOP_READ, a});
      for (int n = 0; n < 300 && rdQ.size() > 0; n++) @(negedge clk_sys);
      repeat (20) @(negedge clk_sys);
      u_prog.readWord(w);
   endtask

   task automatic writeAt(input logic [13:0] a, input logic [13:0] w, input logic [5:0] ld);
      logic [29:0] q;
      u_prog.sendCmd(ld);
      u_prog.sendWord(w);
      if (ld == spv_pkg::CMD_LOAD_CFG) repeat (7) u_prog.sendCmd(spv_pkg::CMD_INC_ADDR);
      u_prog.sendCmd(spv_pkg::CMD_BEGIN_PROG);
      takeReq(q);
      check(q[29:14], {spv_pkg::MOP_WRITE, a});
      q[13:0] = q[13:0] ^ ((ld == spv_pkg::CMD_LOAD_CFG) ? cfgExp(w, lowVoltageEntryPin) : w);
      check({2'h0, q[13:0]}, 16'h0000);
   endtask

   task automatic entry(input logic hv);
      u_prog.idle(3);
      @(negedge clk_sys);
      if (hv) highVoltageEntryLevel = 1'b1;
      else lowVoltageEntryPin = 1'b1;
      repeat (6) @(negedge clk_sys);
      // Link leaves its reset after two clocks; a third would count as a command bit
      u_prog.idle(2);
   endtask

   task automatic leave();
      int n;
      @(negedge clk_sys);
      highVoltageEntryLevel = 1'b0;
      lowVoltageEntryPin = 1'b0;
      for (n = 0; n < 10 && deviceResetReq !== 1'b1; n++) @(negedge clk_sys);
      check({15'h0, n < 10}, 16'h0001);
      @(negedge clk_sys);
      check({14'h0, deviceResetReq, progMode}, 16'h0000);
      check({2'h0, readChecksum}, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [13:0] w, d, sum, cs0;
      logic [29:0] q;
      {rst_n, highVoltageEntryLevel, lowVoltageEntryPin} = 3'h0;
      {clkEn, lowVoltageProgEnable, codeProtectBit, dataProtectBit} = 4'hf;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check({13'h0, progMode, userIdAccess, memValid}, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         mem[i] = r[13:0];
         mem[spv_pkg::ADDR_USER_ID + i] = r[27:14];
      end
      entry(1'b1);
      check({14'h0, progMode, userIdAccess}, 16'h0003);
      check({15'h0, entryPinIsGpio}, 16'h0000);
      readAt(spv_pkg::ADDR_RESET, w);
      check({2'h0, w}, {2'h0, memRead(14'h0000)});
      r = rnd();
      writeAt(14'h0000, r[13:0], spv_pkg::CMD_LOAD_PROG);
      u_prog.sendCmd(spv_pkg::CMD_INC_ADDR);
      writeAt(14'h0001, r[27:14], spv_pkg::CMD_LOAD_PROG);
      readAt(14'h0001, w);
      check({2'h0, w}, {2'h0, r[27:14]});
      r = rnd();
      d = r[13:0];
      d[spv_pkg::CFG_LVP_BIT] = 1'b0;
      u_prog.sendCmd(spv_pkg::CMD_LOAD_CFG);
      u_prog.sendWord(d);
      cs0 = readChecksum;
      sum = 14'h0000;
      for (int i = 0; i < 4; i++) begin
         readAt(spv_pkg::ADDR_USER_ID + i, w);
         check({2'h0, w}, {2'h0, memRead(spv_pkg::ADDR_USER_ID + i)});
         sum = sum + (w & spv_pkg::USER_ID_CSUM_MASK);
         u_prog.sendCmd(spv_pkg::CMD_INC_ADDR);
      end
      check({2'h0, readChecksum - cs0}, {2'h0, sum});
      writeAt(spv_pkg::ADDR_CONFIG, d, spv_pkg::CMD_LOAD_CFG);
      leave();
      $display("test high voltage session done");
      codeProtectBit = 1'b0;
      entry(1'b1);
      readAt(spv_pkg::ADDR_RESET, w);
      check({2'h0, w}, 16'h0000);
      u_prog.sendCmd(spv_pkg::CMD_BULK_ERASE);
      takeReq(q);
      check({14'h0, q[29:28]}, {14'h0, spv_pkg::MOP_ERASE});
      codeProtectBit = 1'b1;
      readAt(spv_pkg::ADDR_RESET, w);
      check({2'h0, w}, 16'h3fff);
      leave();
      $display("test protection done");
      // Protected config write must not lift either protect bit
      {codeProtectBit, dataProtectBit} = 2'h0;
      d[spv_pkg::CFG_CP_BIT] = 1'b1;
      d[spv_pkg::CFG_CPD_BIT] = 1'b1;
      entry(1'b0);
      check({15'h0, progMode}, 16'h0001);
      writeAt(spv_pkg::ADDR_CONFIG, d, spv_pkg::CMD_LOAD_CFG);
      leave();
      $display("test low voltage session done");
      clkEn = 1'b0;
      lowVoltageProgEnable = 1'b0;
      repeat (3) @(negedge clk_sys);
      check({15'h0, entryPinIsGpio}, 16'h0000);
      clkEn = 1'b1;
      repeat (3) @(negedge clk_sys);
      check({15'h0, entryPinIsGpio}, 16'h0001);
      lowVoltageEntryPin = 1'b1;
      repeat (10) @(negedge clk_sys);
      check({15'h0, progMode}, 16'h0000);
      lowVoltageEntryPin = 1'b0;
      entry(1'b1);
      check({15'h0, progMode}, 16'h0001);
      leave();
      $display("test low voltage disabled done");
      complete_run();
   end

   initial begin
      #400000;
      fails++;
      complete_run();
   end
endmodule // tb_serial_program_verify_port

// File: verilog/spv_pkg.sv
package spv_pkg;
   localparam int CMD_W = 6;
   localparam int WORD_W = 14;
   localparam int ADDR_W = 14;
   localparam int LINK_W = 20;
   localparam int MREQ_W = 30;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 30;
   // Commands on the serial link
   localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
   localparam logic [5:0] CMD_LOAD_PROG = 6'h02;
   localparam logic [5:0] CMD_READ_PROG = 6'h04;
   localparam logic [5:0] CMD_INC_ADDR = 6'h06;
   localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
   localparam logic [5:0] CMD_BULK_ERASE = 6'h09;
   // Address map
   localparam logic [13:0] ADDR_RESET = 14'h0000;
   localparam logic [13:0] ADDR_USER_ID = 14'h2000;
   localparam logic [13:0] ADDR_USER_ID_LAST = 14'h2003;
   localparam logic [13:0] ADDR_CONFIG = 14'h2007;
   localparam logic [13:0] ADDR_STEP = 14'h0001;
   // Configuration word fields
   localparam int CFG_LVP_BIT = 7;
   localparam int CFG_CPD_BIT = 8;
   localparam int CFG_CP_BIT = 13;
   localparam logic [13:0] USER_ID_CSUM_MASK = 14'h000f;
   localparam logic [13:0] WORD_ZERO = 14'h0000;
   // Link bit counts
   localparam logic [3:0] LK_CMD_LAST = 4'h5;
   localparam logic [3:0] LK_DATA_LAST = 4'hd;
   localparam logic [3:0] LK_READ_LAST = 4'he;
   // Memory request opcodes
   localparam logic [1:0] MOP_READ = 2'h0;
   localparam logic [1:0] MOP_WRITE = 2'h1;
   localparam logic [1:0] MOP_ERASE = 2'h2;
   typedef enum logic [1:0] {SS_OFF = 2'b00, SS_HV = 2'b01, SS_LV = 2'b10} spv_sess_t;
   typedef enum logic {EX_IDLE = 1'b0, EX_READ = 1'b1} spv_exec_t;
   typedef enum logic [1:0] {LK_CMD = 2'b00, LK_LOAD = 2'b01, LK_READ = 2'b10} spv_link_t;
endpackage

// File: verilog/spv_prog_port.sv
// Notes on behaviour
// - Program memory reads return zero while code protection is active.
// - Only bulk erase clears protection; it erases all program and data memory.
// - User ID words 2000h-2003h reachable only in program/verify mode.
// - Checksum uses only low 4 bits of each 14-bit user ID word.
// - In program mode one pin is serial clock, another serial data.
// - Entering program mode sets the address counter to zero.
// - Six-bit command first; loads bring 14 data bits, reads return 14 bits.
// - Low-voltage entry enabled when configuration enable bit is 1.
// - With low-voltage enabled, entry pin is reserved, not general I/O.
// - With low-voltage enabled, logic one on entry pin starts programming.
// - High-voltage entry stays available while low-voltage entry is enabled.
// - Enable bit 0 makes entry pin ordinary I/O; only high voltage enters.
// - Enable bit writable only in high-voltage sessions; refused in low-voltage ones.
`timescale 1ns/100ps

module spv_fifo #(
   parameter int WIDTH = 30,
   parameter int DEPTH = 32
) (
   // System side
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign inReady = count_q != (AW+1)'(DEPTH);
   assign outValid = count_q != '0;
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk_sys) begin
      if (clkEn && push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (clkEn) begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // spv_fifo

////////////////////////////////////////////////////////////////////////////////

module spv_prog_port (
   // System
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Serial link
   input wire logic serialProgClockPin,
   input wire logic serialProgDataPinIn,
   output logic serialProgDataPinOut,
   output logic serialProgDataPinOe,
   // Entry and configuration
   input wire logic highVoltageEntryLevel,
   input wire logic lowVoltageEntryPin,
   input wire logic lowVoltageProgEnable,
   input wire logic codeProtectBit,
   input wire logic dataProtectBit,
   // Status toward the core
   output logic progMode,
   output logic deviceResetReq,
   output logic entryPinIsGpio,
   output logic userIdAccess,
   output logic [13:0] readChecksum,
   // Memory requests
   output logic memValid,
   input wire logic memReady,
   output logic [1:0] memOp,
   output logic [13:0] memAddr,
   output logic [13:0] memWdata,
   input wire logic rdValid,
   input wire logic [13:0] rdData
);
   spv_pkg::spv_sess_t sess_q;
   spv_pkg::spv_exec_t exec_q;
   spv_pkg::spv_link_t lk_q;
   logic hvS1, hvS2, lvS1, lvS2;
   logic tglS1, tglS2, tglS3;
   logic cmdPend_q;
   logic [19:0] cmdWord_q;
   logic [13:0] latch_q, pc_q, rdWord_q, csum_q;
   logic resetReq_q, gpio_q;
   logic fifoInValid, fifoInReady, isMem, cmdDone, inUserId;
   logic [1:0] mop;
   logic [13:0] wdata, rdMasked;
   logic [5:0] cmd;
   // Link domain
   logic actS1, actS2, linkTgl_q, oe_q;
   logic [3:0] cnt_q;
   logic [5:0] cmdSh_q;
   logic [13:0] sh_q;
   logic [19:0] linkWord_q;
   logic [5:0] cmdIn;
   logic isLoad;

   assign progMode = sess_q != spv_pkg::SS_OFF;
   assign deviceResetReq = resetReq_q;
   assign entryPinIsGpio = gpio_q;
   assign userIdAccess = progMode;
   assign readChecksum = csum_q;
   assign cmd = cmdWord_q[19:14];
   assign inUserId = pc_q >= spv_pkg::ADDR_USER_ID && pc_q <= spv_pkg::ADDR_USER_ID_LAST;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {hvS1, hvS2, lvS1, lvS2} <= 4'h0;
         {tglS1, tglS2, tglS3} <= 3'h0;
      end else if (clkEn) begin
         hvS1 <= highVoltageEntryLevel;
         hvS2 <= hvS1;
         lvS1 <= lowVoltageEntryPin;
         lvS2 <= lvS1;
         tglS1 <= linkTgl_q;
         tglS2 <= tglS1;
         tglS3 <= tglS2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Session entry and exit
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sess_q <= spv_pkg::SS_OFF;
         resetReq_q <= 1'b0;
         gpio_q <= 1'b0;
      end else if (clkEn) begin
         resetReq_q <= 1'b0;
         gpio_q <= !lowVoltageProgEnable;
         case (sess_q)
            spv_pkg::SS_OFF: begin
               if (hvS2) begin
                  sess_q <= spv_pkg::SS_HV;
               end else if (lvS2 && lowVoltageProgEnable) begin
                  sess_q <= spv_pkg::SS_LV;
               end
            end
            spv_pkg::SS_HV: begin
               if (!hvS2) begin
                  sess_q <= spv_pkg::SS_OFF;
                  resetReq_q <= 1'b1;
               end
            end
            spv_pkg::SS_LV: begin
               if (!lvS2) begin
                  sess_q <= spv_pkg::SS_OFF;
                  resetReq_q <= 1'b1;
               end
            end
            default: sess_q <= spv_pkg::SS_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   always_comb begin
      isMem = 1'b1;
      mop = spv_pkg::MOP_READ;
      case (cmd)
         spv_pkg::CMD_READ_PROG: mop = spv_pkg::MOP_READ;
         spv_pkg::CMD_BEGIN_PROG: mop = spv_pkg::MOP_WRITE;
         spv_pkg::CMD_BULK_ERASE: mop = spv_pkg::MOP_ERASE;
         default: isMem = 1'b0;
      endcase
      wdata = latch_q;
      if (pc_q == spv_pkg::ADDR_CONFIG) begin
         wdata[spv_pkg::CFG_CP_BIT] = latch_q[spv_pkg::CFG_CP_BIT] & codeProtectBit;
         wdata[spv_pkg::CFG_CPD_BIT] = latch_q[spv_pkg::CFG_CPD_BIT] & dataProtectBit;
         if (sess_q == spv_pkg::SS_LV) begin
            wdata[spv_pkg::CFG_LVP_BIT] = lowVoltageProgEnable;
         end
      end
      rdMasked = (!codeProtectBit && pc_q < spv_pkg::ADDR_USER_ID) ? spv_pkg::WORD_ZERO : rdData;
   end

   assign fifoInValid = progMode && cmdPend_q && exec_q == spv_pkg::EX_IDLE && isMem;
   assign cmdDone = cmdPend_q && exec_q == spv_pkg::EX_IDLE && (!isMem || fifoInReady);

   ////////////////////////////////////////////////////////////////////////////
   // Command execution
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmdPend_q <= 1'b0;
         cmdWord_q <= '0;
      end else if (clkEn) begin
         if (cmdDone || !progMode) begin
            cmdPend_q <= 1'b0;
         end
         if (tglS2 != tglS3 && progMode) begin
            cmdPend_q <= 1'b1;
            cmdWord_q <= linkWord_q;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         exec_q <= spv_pkg::EX_IDLE;
         pc_q <= spv_pkg::ADDR_RESET;
         latch_q <= '0;
         rdWord_q <= '0;
         csum_q <= '0;
      end else if (clkEn) begin
         if (!progMode) begin
            exec_q <= spv_pkg::EX_IDLE;
            pc_q <= spv_pkg::ADDR_RESET;
            csum_q <= '0;
         end else begin
            case (exec_q)
               spv_pkg::EX_IDLE: begin
                  if (cmdDone) begin
                     case (cmd)
                        spv_pkg::CMD_LOAD_CFG: begin
                           pc_q <= spv_pkg::ADDR_USER_ID;
                           latch_q <= cmdWord_q[13:0];
                        end
                        spv_pkg::CMD_LOAD_PROG: latch_q <= cmdWord_q[13:0];
                        spv_pkg::CMD_INC_ADDR: pc_q <= pc_q + spv_pkg::ADDR_STEP;
                        spv_pkg::CMD_READ_PROG: exec_q <= spv_pkg::EX_READ;
                        default: exec_q <= spv_pkg::EX_IDLE;
                     endcase
                  end
               end
               spv_pkg::EX_READ: begin
                  if (rdValid) begin
                     rdWord_q <= rdMasked;
                     csum_q <= csum_q + (inUserId ? rdMasked & spv_pkg::USER_ID_CSUM_MASK : rdMasked);
                     exec_q <= spv_pkg::EX_IDLE;
                  end
               end
               default: exec_q <= spv_pkg::EX_IDLE;
            endcase
         end
      end
   end

   spv_fifo #(
      .WIDTH(spv_pkg::FIFO_WIDTH),
      .DEPTH(spv_pkg::FIFO_DEPTH)
   ) reqFifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData({mop, pc_q, wdata}),
      .outValid(memValid),
      .outReady(memReady),
      .outData({memOp, memAddr, memWdata})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Link domain, clocked by the programmer
   always_ff @(posedge serialProgClockPin) begin
      actS1 <= progMode;
      actS2 <= actS1;
   end

   assign serialProgDataPinOe = oe_q;
   assign serialProgDataPinOut = sh_q[0];
   assign cmdIn = {serialProgDataPinIn, cmdSh_q[5:1]};
   assign isLoad = cmdIn == spv_pkg::CMD_LOAD_CFG || cmdIn == spv_pkg::CMD_LOAD_PROG;

   always_ff @(posedge serialProgClockPin) begin
      if (!actS2) begin
         lk_q <= spv_pkg::LK_CMD;
         cnt_q <= '0;
         oe_q <= 1'b0;
         cmdSh_q <= '0;
         sh_q <= '0;
         linkTgl_q <= 1'b0;
         linkWord_q <= '0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         case (lk_q)
            spv_pkg::LK_CMD: begin
               cmdSh_q <= cmdIn;
               if (cnt_q == spv_pkg::LK_CMD_LAST) begin
                  cnt_q <= '0;
                  if (cmdIn == spv_pkg::CMD_READ_PROG) begin
                     lk_q <= spv_pkg::LK_READ;
                  end else if (isLoad) begin
                     lk_q <= spv_pkg::LK_LOAD;
                  end
                  // Loads hand over only once their data word is complete
                  if (!isLoad) begin
                     linkWord_q <= {cmdIn, spv_pkg::WORD_ZERO};
                     linkTgl_q <= !linkTgl_q;
                  end
               end
            end
            spv_pkg::LK_LOAD: begin
               sh_q <= {serialProgDataPinIn, sh_q[13:1]};
               if (cnt_q == spv_pkg::LK_DATA_LAST) begin
                  cnt_q <= '0;
                  lk_q <= spv_pkg::LK_CMD;
                  linkWord_q <= {cmdSh_q, serialProgDataPinIn, sh_q[13:1]};
                  linkTgl_q <= !linkTgl_q;
               end
            end
            spv_pkg::LK_READ: begin
               if (cnt_q == '0) begin
                  sh_q <= rdWord_q;
                  oe_q <= 1'b1;
               end else begin
                  sh_q <= {1'b0, sh_q[13:1]};
               end
               if (cnt_q == spv_pkg::LK_READ_LAST) begin
                  cnt_q <= '0;
                  oe_q <= 1'b0;
                  lk_q <= spv_pkg::LK_CMD;
               end
            end
            default: lk_q <= spv_pkg::LK_CMD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n || !clkEn);

   a_read_mask_zero: assert property (
      exec_q == spv_pkg::EX_READ && rdValid && !codeProtectBit && pc_q < spv_pkg::ADDR_USER_ID
      |=> rdWord_q == 14'h0000) else $error("protected read not zero");
   a_cp_not_raised: assert property (
      fifoInValid && mop == spv_pkg::MOP_WRITE && pc_q == spv_pkg::ADDR_CONFIG && !codeProtectBit
      |-> !wdata[spv_pkg::CFG_CP_BIT]) else $error("write lifted code protection");
   a_user_id_gated: assert property (
      fifoInValid |-> sess_q != spv_pkg::SS_OFF) else $error("request outside program mode");
   a_csum_nibble: assert property (
      exec_q == spv_pkg::EX_READ && rdValid && inUserId && progMode
      |=> (csum_q - $past(csum_q)) <= 14'h000f) else $error("user id checksum too wide");
   a_entry_addr_zero: assert property (
      $rose(progMode) |-> pc_q == 14'h0000) else $error("address not zero at entry");
   a_lv_entry: assert property (
      sess_q == spv_pkg::SS_OFF && !hvS2 && lvS2 && lowVoltageProgEnable
      |=> sess_q == spv_pkg::SS_LV) else $error("low voltage entry missed");
   a_hv_entry: assert property (
      sess_q == spv_pkg::SS_OFF && hvS2 |=> sess_q == spv_pkg::SS_HV) else $error("hv entry missed");
   a_lvp_refused: assert property (
      fifoInValid && sess_q == spv_pkg::SS_LV && pc_q == spv_pkg::ADDR_CONFIG
      |-> wdata[spv_pkg::CFG_LVP_BIT] == lowVoltageProgEnable) else $error("enable bit written");
   a_exit_reset: assert property (
      sess_q == spv_pkg::SS_HV && !hvS2 |=> deviceResetReq && !progMode ##1 !deviceResetReq)
      else $error("exit without reset request");

   c_hv_session: cover property (sess_q == spv_pkg::SS_HV && memValid && memReady);
   c_lv_session: cover property (sess_q == spv_pkg::SS_LV ##1 deviceResetReq);
   c_read_done: cover property (exec_q == spv_pkg::EX_READ && rdValid);
   c_fifo_full: cover property (progMode && !fifoInReady);
endmodule // spv_prog_port
